// [bdmc_pkg.sv]
// constants and types for the banked data memory core register block
// assumes a single 40 MHz clock domain shared with the instruction logic
`default_nettype none
package bdmc_pkg;
  localparam int unsigned NUM_BANKS = 32;
  localparam int unsigned BANK_BYTES = 128;
  localparam int unsigned GPR_BYTES = 80;
  localparam int unsigned CMN_BYTES = 16;
  // banks that carry general purpose ram; the rest read as zero
  localparam int unsigned GPR_BANKS = 4;
  localparam int unsigned GPR_IDX_W = 9;
  localparam logic [6:0] OFF_INDIRECT_PORT_ZERO = 7'h00;
  localparam logic [6:0] OFF_INDIRECT_PORT_ONE = 7'h01;
  localparam logic [6:0] OFF_PCL = 7'h02;
  localparam logic [6:0] OFF_FLAGS = 7'h03;
  localparam logic [6:0] OFF_PTR0_LO = 7'h04;
  localparam logic [6:0] OFF_PTR0_HI = 7'h05;
  localparam logic [6:0] OFF_PTR1_LO = 7'h06;
  localparam logic [6:0] OFF_PTR1_HI = 7'h07;
  localparam logic [6:0] OFF_BANK_SEL = 7'h08;
  localparam logic [6:0] OFF_ACCUM = 7'h09;
  localparam logic [6:0] OFF_PC_LATCH = 7'h0A;
  localparam logic [6:0] OFF_INT_CTRL = 7'h0B;
  localparam logic [6:0] OFF_SFR_FIRST = 7'h0C;
  localparam logic [6:0] OFF_GPR_FIRST = 7'h20;
  localparam logic [6:0] OFF_CMN_FIRST = 7'h70;
  localparam int unsigned PTR_PM_BIT = 15;
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_DC = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_PD = 3;
  localparam int unsigned FLG_TO = 4;
  localparam logic [4:0] FLAGS_RST = 5'h18;
  localparam logic [7:0] INT_CTRL_RST = 8'h01;
  localparam logic [7:0] INT_CTRL_MASK = 8'hC1;
  localparam logic [7:0] BYTE_RST = 8'h00;
  typedef enum logic [2:0] {
    OP_MOV = 3'b000,
    OP_LOGIC = 3'b001,
    OP_ADD = 3'b010,
    OP_SUB = 3'b011,
    OP_RLC = 3'b100,
    OP_RRC = 3'b101,
    OP_CLR = 3'b110
  } bdmc_op_t;
  typedef enum logic [2:0] {
    RG_CORE = 3'b000,
    RG_SFR = 3'b001,
    RG_GPR = 3'b010,
    RG_CMN = 3'b011,
    RG_NONE = 3'b100
  } bdmc_region_t;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_PMRD = 1'b1
  } bdmc_state_t;
endpackage : bdmc_pkg
`default_nettype wire

// [bdmc_core_regs.sv]
// banked data memory with core register window, pointer indirection,
// program memory reads through the pointers and the flag register
// assumes the instruction logic issues one access at a time, honours
// busy_o, and that program memory answers in the cycle of pm_req_o
`timescale 1ns/10ps
`default_nettype none
module bdmc_core_regs (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic acc_valid_i,
  input wire logic acc_wr_i,
  input wire logic [6:0] acc_off_i,
  input wire bdmc_pkg::bdmc_op_t alu_op_i,
  input wire logic [7:0] alu_a_i,
  input wire logic [7:0] alu_b_i,
  input wire logic wdt_clr_i,
  input wire logic sleep_i,
  input wire logic wdt_timeout_i,
  input wire logic [13:0] pm_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o,
  output logic pm_req_o,
  output logic [14:0] pm_addr_o,
  output logic [7:0] flags_o,
  output logic [7:0] accum_o,
  output logic [4:0] bank_sel_o
);
  import bdmc_pkg::*;

  // mask of flags an op owns, as {zero, digit carry, carry}
  function automatic logic [2:0] op_flags(input bdmc_op_t op);
    case (op)
      OP_ADD, OP_SUB: op_flags = 3'b111;
      OP_RLC, OP_RRC: op_flags = 3'b001;
      OP_LOGIC, OP_CLR: op_flags = 3'b100;
      default: op_flags = 3'b000;
    endcase
  endfunction : op_flags

  // returns {result, zero, digit carry, carry}
  function automatic logic [10:0] alu(input bdmc_op_t op,
      input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    s = 9'h000;
    h = 5'h00;
    r = b;
    case (op)
      OP_ADD: begin
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        r = s[7:0];
      end
      OP_SUB: begin
        // borrow out shows as a cleared carry
        s = {1'b0, a} + {1'b0, ~b} + 9'h001;
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        r = s[7:0];
      end
      OP_RLC: begin
        r = {a[6:0], cin};
        s = {a[7], 8'h00};
      end
      OP_RRC: begin
        r = {cin, a[7:1]};
        s = {a[0], 8'h00};
      end
      OP_CLR: r = 8'h00;
      default: r = b;
    endcase
    alu = {r, (r == 8'h00), h[4], s[8]};
  endfunction : alu

  logic [15:0] ptr0_r;
  logic [15:0] ptr1_r;
  logic [4:0] bank_sel_r;
  logic [7:0] accum_r;
  logic [7:0] pcl_r;
  logic [6:0] pc_latch_r;
  logic [7:0] int_ctrl_r;
  logic [4:0] flg_r;
  logic [7:0] gpr_r [GPR_BANKS*GPR_BYTES];
  logic [7:0] cmn_r [CMN_BYTES];
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic busy_r;
  logic pm_req_r;
  logic [14:0] pm_addr_r;
  bdmc_state_t state_r;

  logic ind;
  logic [15:0] ptr;
  logic to_pm;
  logic bad_ptr;
  logic [11:0] ea;
  logic [4:0] bank;
  logic [6:0] off;
  bdmc_region_t region;
  logic [GPR_IDX_W-1:0] gidx;
  logic [3:0] cidx;
  logic [7:0] rd_val;
  logic take;
  logic we;
  logic [10:0] alu_out;
  logic [7:0] wdat;
  logic [2:0] aff;
  logic flag_we;

  assign take = acc_valid_i && !busy_r;
  assign alu_out = alu(alu_op_i, alu_a_i, alu_b_i, flg_r[FLG_C]);
  assign wdat = alu_out[10:3];

  // address forming and region decode
  always_comb begin
    ind = (acc_off_i == OFF_INDIRECT_PORT_ZERO) || (acc_off_i == OFF_INDIRECT_PORT_ONE);
    ptr = (acc_off_i == OFF_INDIRECT_PORT_ONE) ? ptr1_r : ptr0_r;
    to_pm = ind && ptr[PTR_PM_BIT];
    if (ind) begin
      ea = ptr[11:0];
    end else begin
      ea = {bank_sel_r, acc_off_i};
    end
    // a pointer into the ports themselves or past the 4K space is void
    bad_ptr = ind && !to_pm &&
      ((ptr[14:12] != 3'b000) || (ea[6:0] <= OFF_INDIRECT_PORT_ONE));
    bank = ea[11:7];
    off = ea[6:0];
    if (bad_ptr || to_pm) begin
      region = RG_NONE;
    end else if (off <= OFF_INT_CTRL) begin
      region = RG_CORE;
    end else if (off < OFF_GPR_FIRST) begin
      region = RG_SFR;
    end else if (off < OFF_CMN_FIRST) begin
      region = (bank < 5'(GPR_BANKS)) ? RG_GPR : RG_NONE;
    end else begin
      region = RG_CMN;
    end
    gidx = GPR_IDX_W'(32'(bank) * GPR_BYTES
      + 32'(off) - 32'(OFF_GPR_FIRST));
    cidx = off[3:0];
  end

  // read mux; special function and missing locations give zero
  always_comb begin
    rd_val = 8'h00;
    case (region)
      RG_CORE: begin
        case (off)
          OFF_PCL: rd_val = pcl_r;
          OFF_FLAGS: rd_val = {3'b000, flg_r};
          OFF_PTR0_LO: rd_val = ptr0_r[7:0];
          OFF_PTR0_HI: rd_val = ptr0_r[15:8];
          OFF_PTR1_LO: rd_val = ptr1_r[7:0];
          OFF_PTR1_HI: rd_val = ptr1_r[15:8];
          OFF_BANK_SEL: rd_val = {3'b000, bank_sel_r};
          OFF_ACCUM: rd_val = accum_r;
          OFF_PC_LATCH: rd_val = {1'b0, pc_latch_r};
          OFF_INT_CTRL: rd_val = int_ctrl_r & INT_CTRL_MASK;
          default: rd_val = 8'h00;
        endcase
      end
      RG_GPR: rd_val = gpr_r[gidx];
      RG_CMN: rd_val = cmn_r[cidx];
      default: rd_val = 8'h00;
    endcase
  end

  // program memory is read only; a port write aimed there is dropped
  assign we = take && acc_wr_i && !to_pm;

  // read sequencing and the extra program memory cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      pm_req_r <= 1'b0;
      pm_addr_r <= 15'h0000;
      rd_valid_r <= 1'b0;
      rd_data_r <= BYTE_RST;
    end else begin
      case (state_r)
        ST_IDLE: begin
          rd_valid_r <= 1'b0;
          if (take && !acc_wr_i && to_pm) begin
            state_r <= ST_PMRD;
            busy_r <= 1'b1;
            pm_req_r <= 1'b1;
            pm_addr_r <= ptr[14:0];
          end else if (take && !acc_wr_i) begin
            rd_valid_r <= 1'b1;
            rd_data_r <= rd_val;
          end
        end
        ST_PMRD: begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
          pm_req_r <= 1'b0;
          rd_valid_r <= 1'b1;
          rd_data_r <= pm_data_i[7:0];
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
          pm_req_r <= 1'b0;
          rd_valid_r <= 1'b0;
        end
      endcase
    end
  end

  // core register writes, one window for all banks
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr0_r <= 16'h0000;
      ptr1_r <= 16'h0000;
      bank_sel_r <= 5'h00;
      accum_r <= BYTE_RST;
      pcl_r <= BYTE_RST;
      pc_latch_r <= 7'h00;
      int_ctrl_r <= INT_CTRL_RST;
    end else if (we && region == RG_CORE) begin
      case (off)
        OFF_PCL: pcl_r <= wdat;
        OFF_PTR0_LO: ptr0_r[7:0] <= wdat;
        OFF_PTR0_HI: ptr0_r[15:8] <= wdat;
        OFF_PTR1_LO: ptr1_r[7:0] <= wdat;
        OFF_PTR1_HI: ptr1_r[15:8] <= wdat;
        OFF_BANK_SEL: bank_sel_r <= wdat[4:0];
        OFF_ACCUM: accum_r <= wdat;
        OFF_PC_LATCH: pc_latch_r <= wdat[6:0];
        OFF_INT_CTRL: int_ctrl_r <= wdat & INT_CTRL_MASK;
        default: accum_r <= accum_r;
      endcase
    end
  end

  // banked and common ram; ram is not reset
  always_ff @(posedge sys_clk_i) begin
    if (we && region == RG_GPR) begin
      gpr_r[gidx] <= wdat;
    end
    if (we && region == RG_CMN) begin
      cmn_r[cidx] <= wdat;
    end
  end

  assign aff = (take && acc_wr_i) ? op_flags(alu_op_i) : 3'b000;
  assign flag_we = we && region == RG_CORE && off == OFF_FLAGS;

  // one process owns the flag register so no bit has two drivers;
  // an instruction that owns any arithmetic flag locks out the register
  // write to all three, so bits it does not own keep their value
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flg_r <= FLAGS_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (aff[i]) begin
          flg_r[i] <= alu_out[i];
        end else if (flag_we && aff == 3'b000) begin
          flg_r[i] <= wdat[i];
        end
      end
      // reset status pair: hardware only, set wins over clear
      if (wdt_clr_i || sleep_i) begin
        flg_r[FLG_TO] <= 1'b1;
      end else if (wdt_timeout_i) begin
        flg_r[FLG_TO] <= 1'b0;
      end
      if (wdt_clr_i) begin
        flg_r[FLG_PD] <= 1'b1;
      end else if (sleep_i) begin
        flg_r[FLG_PD] <= 1'b0;
      end
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign busy_o = busy_r;
  assign pm_req_o = pm_req_r;
  assign pm_addr_o = pm_addr_r;
  assign flags_o = {3'b000, flg_r};
  assign accum_o = accum_r;
  assign bank_sel_o = bank_sel_r;

  default clocking dcb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  pm_extra_cycle_a: assert property (
    take && !acc_wr_i && to_pm |=>
      busy_o && !rd_valid_o ##1 rd_valid_o && !busy_o)
    else $error("program memory read timing wrong");

  pm_low_byte_a: assert property (
    pm_req_o |=> rd_data_o == $past(pm_data_i[7:0]))
    else $error("program memory byte not delivered");

  pm_no_write_a: assert property (
    take && acc_wr_i && to_pm && alu_op_i == OP_MOV |=>
      $stable(accum_o) && $stable(bank_sel_o) && !pm_req_o)
    else $error("write through port changed state");

  unimp_zero_a: assert property (
    take && !acc_wr_i && !to_pm && region inside {RG_SFR, RG_NONE}
      |=> rd_valid_o && rd_data_o == 8'h00)
    else $error("unimplemented read not zero");

  core_all_banks_a: assert property (
    take && !acc_wr_i && acc_off_i == OFF_ACCUM |=>
      rd_data_o == $past(accum_o))
    else $error("core register bank dependent");

  bank_select_a: assert property (
    we && region == RG_CORE && off == OFF_BANK_SEL |=>
      bank_sel_o == $past(wdat[4:0]) ##0 rd_valid_o == 1'b0)
    else $error("bank select not loaded");

  flag_top_zero_a: assert property (
    flags_o[7:5] == 3'b000)
    else $error("flag top bits not zero");

  flag_guard_a: assert property (
    flag_we && alu_op_i == OP_ADD |=>
      flags_o[2:0] == $past(alu_out[2:0]))
    else $error("flag write overrode add result");

  clear_flags_a: assert property (
    flag_we && alu_op_i == OP_CLR && !wdt_clr_i && !sleep_i
      && !wdt_timeout_i |=>
      flags_o[FLG_Z] && $stable(flags_o[4:3]) && $stable(flags_o[1:0]))
    else $error("clearing flags went wrong");

  sleep_flags_a: assert property (
    sleep_i && !wdt_clr_i |=> flags_o[4:3] == 2'b10)
    else $error("sleep flags wrong");

  timeout_flag_a: assert property (
    wdt_timeout_i && !wdt_clr_i && !sleep_i |=> !flags_o[FLG_TO])
    else $error("timeout flag not cleared");

  sub_borrow_a: assert property (
    take && acc_wr_i && alu_op_i == OP_SUB && alu_a_i >= alu_b_i
      |=> flags_o[FLG_C])
    else $error("subtract carry polarity wrong");

endmodule : bdmc_core_regs
`default_nettype wire

// [bdmc_pm_model.sv]
// program memory model standing behind the block's read strobe
// assumes the block samples the word in the cycle its strobe is high
`timescale 1ns/10ps
`default_nettype none
module bdmc_pm_model (
  input wire logic sys_clk_i,
  input wire logic pm_req_i,
  input wire logic [14:0] pm_addr_i,
  output logic [13:0] pm_data_o
);
  logic [13:0] last_r = 14'h0000;
  // outside the strobe the bus toggles so a stale word never looks valid
  always_comb begin
    pm_data_o = pm_req_i ? (pm_addr_i[13:0] ^ 14'h2A5C) : ~last_r;
  end
  always_ff @(posedge sys_clk_i) begin
    last_r <= pm_data_o;
  end
endmodule : bdmc_pm_model
`default_nettype wire

// [banked_data_memory_core_regs_tb_top.sv]
// self-checking bench for the banked core register block
// assumes the program memory model answers within the strobe cycle
`timescale 1ns/10ps
`default_nettype none
module banked_data_memory_core_regs_tb_top;
  import bdmc_pkg::*;
  logic sys_clk, resetn, acc_valid, acc_wr, wdt_clr, sleep_p, wdt_to;
  logic rd_valid, busy, pm_req;
  logic [6:0] acc_off;
  bdmc_op_t alu_op;
  logic [7:0] alu_a, alu_b, rd_data, flags, accum, cm, w;
  logic [13:0] pm_data;
  logic [14:0] pm_addr;
  logic [4:0] bank_sel, ef;
  logic [7:0] expq[$];
  logic [7:0] v[4];
  int mismatches, checks_done, cyc;
  int unsigned seed;

  always #12.5 sys_clk = ~sys_clk;

  bdmc_core_regs i_bdmc_core_regs (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .acc_valid_i(acc_valid),
    .acc_wr_i(acc_wr), .acc_off_i(acc_off), .alu_op_i(alu_op),
    .alu_a_i(alu_a), .alu_b_i(alu_b), .wdt_clr_i(wdt_clr),
    .sleep_i(sleep_p), .wdt_timeout_i(wdt_to), .pm_data_i(pm_data),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .busy_o(busy),
    .pm_req_o(pm_req), .pm_addr_o(pm_addr), .flags_o(flags),
    .accum_o(accum), .bank_sel_o(bank_sel)
  );
  bdmc_pm_model i_bdmc_pm_model (
    .sys_clk_i(sys_clk), .pm_req_i(pm_req), .pm_addr_i(pm_addr),
    .pm_data_o(pm_data)
  );

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : cmp

  // read results arrive in request order, so a queue suffices
  always @(posedge sys_clk) begin
    cyc++;
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) begin
        mismatches++;
        $display("MISMATCH rd_data exp none got %h", rd_data);
      end else begin
        cmp("rd_data", {8'h00, expq.pop_front()}, {8'h00, rd_data});
      end
    end
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic acc(input logic wr, input logic [6:0] off,
                     input bdmc_op_t op, input logic [7:0] a,
                     input logic [7:0] b);
    @(negedge sys_clk);
    acc_valid = 1'b1;
    acc_wr = wr;
    acc_off = off;
    alu_op = op;
    alu_a = a;
    alu_b = b;
    @(negedge sys_clk);
    acc_valid = 1'b0;
  endtask : acc

  task automatic rd(input logic [6:0] off, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, off, OP_MOV, 8'h00, 8'h00);
  endtask : rd

  task automatic wr(input logic [6:0] off, input logic [7:0] b);
    acc(1'b1, off, OP_MOV, 8'h00, b);
  endtask : wr

  task automatic bank(input logic [4:0] n);
    wr(OFF_BANK_SEL, {3'b000, n});
    cmp("bank_sel", {11'h000, n}, {11'h000, bank_sel});
  endtask : bank

  task automatic pm_rd(input logic [14:0] ad);
    logic [13:0] wd;
    wd = ad[13:0] ^ 14'h2A5C;
    expq.push_back(wd[7:0]);
    @(negedge sys_clk);
    acc_valid = 1'b1;
    acc_wr = 1'b0;
    acc_off = OFF_INDIRECT_PORT_ZERO;
    @(negedge sys_clk);
    cmp("busy", 16'h0001, {15'h0000, busy});
    cmp("pm_req", 16'h0001, {15'h0000, pm_req});
    cmp("pm_addr", {1'b0, ad}, {1'b0, pm_addr});
    // held through the busy cycle: must be dropped, not answered
    acc_off = OFF_ACCUM;
    @(negedge sys_clk);
    acc_valid = 1'b0;
    cmp("busy_end", 16'h0000, {15'h0000, busy});
  endtask : pm_rd

  task automatic alu(input logic [6:0] off, input bdmc_op_t op,
                     input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [2:0] om;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    if (op == OP_SUB) begin
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    end
    r = s[7:0];
    om = 3'b111;
    case (op)
      OP_ADD, OP_SUB: ef[2:0] = {r == 8'h00, h[4], s[8]};
      OP_RLC: begin
        r = {a[6:0], ef[0]};
        ef[0] = a[7];
        om = 3'b001;
      end
      OP_RRC: begin
        r = {ef[0], a[7:1]};
        ef[0] = a[0];
        om = 3'b001;
      end
      OP_MOV: begin
        r = b;
        om = 3'b000;
      end
      OP_LOGIC: begin
        r = b;
        ef[2] = (b == 8'h00);
        om = 3'b100;
      end
      default: begin
        r = 8'h00;
        ef[2] = 1'b1;
      end
    endcase
    if (off == OFF_FLAGS && om == 3'b000) begin
      ef[2:0] = r[2:0];
    end
    acc(1'b1, off, op, a, b);
    if (off == OFF_ACCUM) begin
      cmp("accum", {8'h00, r}, {8'h00, accum});
    end
    cmp("flags", {11'h000, ef}, {8'h00, flags});
  endtask : alu

  task automatic ev(input logic c, input logic s, input logic t,
                    input logic [1:0] tp);
    @(negedge sys_clk);
    wdt_clr = c;
    sleep_p = s;
    wdt_to = t;
    @(negedge sys_clk);
    wdt_clr = 1'b0;
    sleep_p = 1'b0;
    wdt_to = 1'b0;
    @(negedge sys_clk);
    ef[4:3] = tp;
    cmp("flags_ev", {11'h000, ef}, {8'h00, flags});
  endtask : ev

  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    {acc_valid, acc_wr, wdt_clr, sleep_p, wdt_to} = 5'h00;
    acc_off = 7'h00;
    alu_op = OP_MOV;
    alu_a = 8'h00;
    alu_b = 8'h00;
    ef = 5'h18;
    mismatches = 0;
    checks_done = 0;
    cyc = 0;
    seed = $urandom(77665);
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    cmp("flags_rst", 16'h0018, {8'h00, flags});
    cmp("accum_rst", 16'h0000, {8'h00, accum});
    rd(OFF_INT_CTRL, 8'h01);
    rd(OFF_FLAGS, 8'h18);
    for (int i = 0; i < 4; i++) begin
      bank(i[4:0]);
      v[i] = 8'($urandom);
      cm = 8'($urandom);
      wr(OFF_GPR_FIRST + i[6:0], v[i]);
      wr(OFF_CMN_FIRST, cm);
    end
    for (int i = 0; i < 4; i++) begin
      bank(i[4:0]);
      rd(OFF_GPR_FIRST + i[6:0], v[i]);
      rd(OFF_CMN_FIRST, cm);
    end
    bank(5'h1F);
    rd(OFF_GPR_FIRST, 8'h00);
    wr(OFF_SFR_FIRST, 8'hAA);
    rd(OFF_SFR_FIRST, 8'h00);
    rd(OFF_INT_CTRL, 8'h01);
    wr(OFF_PTR1_HI, 8'h01);
    wr(OFF_PTR1_LO, 8'hA5);
    bank(5'h03);
    w = 8'($urandom);
    wr(7'h25, w);
    rd(OFF_INDIRECT_PORT_ONE, w);
    w = 8'($urandom);
    wr(OFF_INDIRECT_PORT_ONE, w);
    rd(7'h25, w);
    wr(OFF_PTR0_HI, 8'h81);
    wr(OFF_PTR0_LO, 8'h23);
    pm_rd(15'h0123);
    // same low twelve bits as the pointer: a leaked write would land here
    bank(5'h02);
    wr(7'h23, 8'h3C);
    wr(OFF_INDIRECT_PORT_ZERO, 8'h55);
    cmp("pm_req_wr", 16'h0000, {15'h0000, pm_req});
    rd(7'h23, 8'h3C);
    pm_rd(15'h0123);
    alu(OFF_ACCUM, OP_ADD, 8'hFF, 8'h01);
    alu(OFF_ACCUM, OP_SUB, 8'h10, 8'h01);
    for (int n = 0; n < 3; n++) begin
      for (int t = 0; t < 2; t++) begin
        for (int o = 0; o < 7; o++) begin
          alu((t == 1) ? OFF_FLAGS : OFF_ACCUM, bdmc_op_t'(o),
              8'($urandom), 8'($urandom));
        end
      end
    end
    ev(1'b0, 1'b1, 1'b0, 2'b10);
    ev(1'b0, 1'b0, 1'b1, 2'b00);
    ev(1'b1, 1'b0, 1'b0, 2'b11);
    ev(1'b0, 1'b1, 1'b1, 2'b10);
    ev(1'b1, 1'b1, 1'b1, 2'b11);
    repeat (3) @(negedge sys_clk);
    cmp("pending", 16'h0000, 16'(expq.size()));
    complete_run();
  end
endmodule : banked_data_memory_core_regs_tb_top
`default_nettype wire
